// ### dcrf_defines.vh
// Constants for the CPU register file: bus map, field layout, masks.
// Assumes inclusion by bare name from the register file and its bus slave.
`ifndef DCRF_DEFINES_VH
`define DCRF_DEFINES_VH

// Bus byte offsets, word indices and general register count
`define DCRF_OFF_EXT_BASE 8'h00
`define DCRF_OFF_AUX_BASE 8'h40
`define DCRF_OFF_GEN_BASE 8'h60
`define DCRF_WIDX_AUX 6'h10
`define DCRF_WIDX_GEN 6'h18
`define DCRF_GEN_COUNT 6'h0D

// Selector codes of the 32-bit control registers
`define DCRF_SEL_DP 4'h0
`define DCRF_SEL_IR0 4'h1
`define DCRF_SEL_IR1 4'h2
`define DCRF_SEL_BK 4'h3
`define DCRF_SEL_SP 4'h4
`define DCRF_SEL_ST 4'h5
`define DCRF_SEL_IE 4'h6
`define DCRF_SEL_IF 4'h7
`define DCRF_SEL_IOF 4'h8
`define DCRF_SEL_RC 4'h9
`define DCRF_SEL_RS 4'hA
`define DCRF_SEL_RE 4'hB
`define DCRF_SEL_PC 4'hC

// Interrupt enable: CPU bits 10-0, DMA bits 26-16
`define DCRF_IE_MASK 32'h07FF07FF

// Flag word bit positions
`define DCRF_ST_C 0
`define DCRF_ST_V 1
`define DCRF_ST_Z 2
`define DCRF_ST_N 3

// General-pin control bit positions
`define DCRF_IOF_DIR0 1
`define DCRF_IOF_OUT0 2
`define DCRF_IOF_IN0 3
`define DCRF_IOF_DIR1 5
`define DCRF_IOF_OUT1 6
`define DCRF_IOF_IN1 7
`define DCRF_IOF_WMASK 32'h00000066

// Reset values
`define DCRF_RST_WORD 32'h00000000
`define DCRF_RST_EXT 40'h0000000000

// Bus responses
`define DCRF_RESP_OKAY 2'h0
`define DCRF_RESP_SLVERR 2'h2

`endif

// ### dcrf_axil_slave.v
// AXI4-Lite slave: one write and one read at a time.
// Assumes the register file answers in the strobe cycle.
`include "dcrf_defines.vh"

module dcrf_axil_slave #(
  parameter ADDR_W = 8
) (
  input wire aclk, // Clock
  input wire aresetn, // Sync reset, low
  input wire clk_en, // Run when high
  input wire awvalid, // AW valid
  output wire awready, // AW ready
  input wire [ADDR_W-1:0] awaddr, // AW address
  input wire wvalid, // W valid
  output wire wready, // W ready
  input wire [31:0] wdata, // W data
  input wire [3:0] wstrb, // W strobes
  output wire bvalid, // B valid
  input wire bready, // B ready
  output wire [1:0] bresp, // B response
  input wire arvalid, // AR valid
  output wire arready, // AR ready
  input wire [ADDR_W-1:0] araddr, // AR address
  output wire rvalid, // R valid
  input wire rready, // R ready
  output wire [31:0] rdata, // R data
  output wire [1:0] rresp, // R response
  output wire wr_stb, // Write pulse
  output wire [ADDR_W-1:0] wr_addr, // Write address
  output wire [31:0] wr_data, // Write data
  output wire [3:0] wr_strb, // Write strobes
  input wire wr_ok, // Write mapped
  output wire rd_stb, // Read pulse
  output wire [ADDR_W-1:0] rd_addr, // Read address
  input wire [31:0] rd_data, // Read value
  input wire rd_ok // Read mapped
);
  reg awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  reg aw_have_r, w_have_r, wr_stb_r, rd_stb_r;
  reg [1:0] bresp_r, rresp_r;
  reg [31:0] rdata_r, wdata_r;
  reg [3:0] wstrb_r;
  reg [ADDR_W-1:0] awaddr_r, araddr_r;

  wire aw_take = awvalid & awready_r;
  wire w_take = wvalid & wready_r;
  wire aw_h = aw_have_r | aw_take;
  wire w_h = w_have_r | w_take;
  wire wr_fire = aw_h & w_h;
  wire bvalid_nxt = wr_stb_r | (bvalid_r & ~bready);
  wire ar_take = arvalid & arready_r;
  wire rvalid_nxt = rd_stb_r | (rvalid_r & ~rready);

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
      bresp_r <= `DCRF_RESP_OKAY;
      rresp_r <= `DCRF_RESP_OKAY;
      rdata_r <= `DCRF_RST_WORD;
      wdata_r <= `DCRF_RST_WORD;
      wstrb_r <= 4'h0;
      awaddr_r <= {ADDR_W{1'b0}};
      araddr_r <= {ADDR_W{1'b0}};
    end else if (clk_en) begin
      if (aw_take)
        awaddr_r <= awaddr;
      if (w_take) begin
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      aw_have_r <= aw_h & ~wr_fire;
      w_have_r <= w_h & ~wr_fire;
      wr_stb_r <= wr_fire;
      // Ready low until the response is taken
      awready_r <= ~aw_h & ~wr_stb_r & ~bvalid_nxt;
      wready_r <= ~w_h & ~wr_stb_r & ~bvalid_nxt;
      bvalid_r <= bvalid_nxt;
      if (wr_stb_r)
        bresp_r <= wr_ok ? `DCRF_RESP_OKAY : `DCRF_RESP_SLVERR;
      if (ar_take)
        araddr_r <= araddr;
      rd_stb_r <= ar_take;
      arready_r <= ~ar_take & ~rd_stb_r & ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (rd_stb_r) begin
        rdata_r <= rd_ok ? rd_data : `DCRF_RST_WORD;
        rresp_r <= rd_ok ? `DCRF_RESP_OKAY : `DCRF_RESP_SLVERR;
      end
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign wr_stb = wr_stb_r;
  assign wr_addr = awaddr_r;
  assign wr_data = wdata_r;
  assign wr_strb = wstrb_r;
  assign rd_stb = rd_stb_r;
  assign rd_addr = araddr_r;
endmodule // dcrf_axil_slave

// ### dcrf_regfile.v
// CPU register file of a signal processor, with AXI4-Lite access.
// Assumes all ports are synchronous to aclk.
// Operation
// [RL1] Float operations use all forty bits.
// [RL2] Integer operations and shifts use bits 31-0; bits 39-32 kept.
// [RL3] Eight auxiliary registers: CPU access, both address units update.
// [RL4] Auxiliary registers double as general registers for multiplier and ALU.
// [RL5] Page pointer low eight bits give the page number.
// [RL6] Index registers feed the address unit.
// [RL7] Block size gives circular addressing its length.
// [RL8] Stack pointer holds the last pushed address.
// [RL9] Push increments first; pop reads, then decrements.
// [RL10] Interrupts, traps, calls, returns, push, pop move the stack pointer.
// [RL11] Operation, load and store results update condition flags.
// [RL12] Status load copies the operand bit for bit.
// [RL13] Enables: CPU bits 10-0, DMA bits 26-16.
// [RL14] Enable one enables, zero disables.
// [RL15] Flag one is pending, zero is not.
// [RL16] Pin control sets direction, reads and drives two general pins.
// [RL17] Loop count holds the repeat count.
// [RL18] Loop start and end hold the repeated block's bounds.
// [RL19] Program counter holds next fetch address; program flow writes it.
// [RL20] Enable bits outside both ranges read zero, ignore writes.
`include "dcrf_defines.vh"

module dcrf_regfile #(
  parameter ADDR_W = 8
) (
  input wire aclk, // Clock
  input wire aresetn, // Sync reset, low
  input wire clk_en, // Run when high
  input wire s_axi_awvalid, // AW valid
  output wire s_axi_awready, // AW ready
  input wire [ADDR_W-1:0] s_axi_awaddr, // AW address
  input wire s_axi_wvalid, // W valid
  output wire s_axi_wready, // W ready
  input wire [31:0] s_axi_wdata, // W data
  input wire [3:0] s_axi_wstrb, // W strobes
  output wire s_axi_bvalid, // B valid
  input wire s_axi_bready, // B ready
  output wire [1:0] s_axi_bresp, // B response
  input wire s_axi_arvalid, // AR valid
  output wire s_axi_arready, // AR ready
  input wire [ADDR_W-1:0] s_axi_araddr, // AR address
  output wire s_axi_rvalid, // R valid
  input wire s_axi_rready, // R ready
  output wire [31:0] s_axi_rdata, // R data
  output wire [1:0] s_axi_rresp, // R response
  input wire ext_wr_en, // Ext write
  input wire [2:0] ext_wr_sel, // Ext write reg
  input wire ext_wr_float, // 1: all 40 bits
  input wire [39:0] ext_wr_data, // Ext write value
  input wire [2:0] ext_rd_sel, // Ext read reg
  output wire [39:0] ext_rd_data, // Ext read, 1 cycle late
  input wire aux_wr_en, // Aux write, ALU/mult
  input wire [2:0] aux_wr_sel, // Aux write reg
  input wire [31:0] aux_wr_data, // Aux write value
  input wire au0_wr_en, // Unit 0 write
  input wire [2:0] au0_wr_sel, // Unit 0 reg
  input wire [31:0] au0_wr_data, // Unit 0 value
  input wire au1_wr_en, // Unit 1 write
  input wire [2:0] au1_wr_sel, // Unit 1 reg
  input wire [31:0] au1_wr_data, // Unit 1 value
  input wire [2:0] aux_rd_sel, // Aux read reg
  output wire [31:0] aux_rd_data, // Aux read, 1 cycle late
  input wire reg_wr_en, // Control write
  input wire [3:0] reg_wr_sel, // Control selector
  input wire [31:0] reg_wr_data, // Control value
  output wire [7:0] page_num, // Direct page
  output wire [31:0] index_0, // Index 0
  output wire [31:0] index_1, // Index 1
  output wire [31:0] block_size, // Circular length
  input wire stk_push, // Push
  input wire stk_pop, // Pop
  output wire [31:0] stack_top, // Stack pointer
  output wire [31:0] stk_addr, // Stack access address
  output wire stk_wr, // Element write pulse
  output wire stk_rd, // Element read pulse
  input wire flag_upd_en, // Result valid
  input wire flag_float, // Float result
  input wire [39:0] flag_res, // Result
  input wire flag_carry, // Carry out
  input wire flag_ovf, // Overflow
  output wire [31:0] cpu_flag_word, // Status word
  input wire [31:0] intr_set, // Request pulses
  output wire [31:0] interrupt_enable, // Enables
  output wire [31:0] interrupt_flags, // Pending
  output wire [31:0] intr_active, // Pending and enabled
  input wire general_pin_0_in, // Pin 0 level
  output wire general_pin_0_out, // Pin 0 drive
  output wire general_pin_0_oe, // Pin 0 enable
  input wire general_pin_1_in, // Pin 1 level
  output wire general_pin_1_out, // Pin 1 drive
  output wire general_pin_1_oe, // Pin 1 enable
  output wire [31:0] loop_count, // Repeat count
  output wire [31:0] loop_start_address, // Repeat start
  output wire [31:0] loop_end_address, // Repeat end
  input wire pc_load, // Counter load
  input wire [31:0] pc_load_data, // Counter value
  input wire pc_step, // Counter advance
  output wire [31:0] program_counter // Fetch address
);
  reg [39:0] ext_r [0:7];
  reg [31:0] aux_r [0:7];
  reg [39:0] ext_rd_r;
  reg [31:0] aux_rd_r;
  reg [31:0] dp_r, ir0_r, ir1_r, bk_r, sp_r, st_r, ie_r, if_r, iof_r;
  reg [31:0] rc_r, rs_r, re_r, pc_r, act_r, stk_addr_r;
  reg stk_wr_r, stk_rd_r, pin0_in_r, pin1_in_r;
  reg [31:0] rd_data, g_data;
  reg rd_ok, wr_ok, g_wen;
  reg [3:0] g_sel;
  reg [31:0] st_nxt;
  integer i;

  wire wr_stb, rd_stb;
  wire [ADDR_W-1:0] wr_addr, rd_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [5:0] wr_widx = wr_addr[7:2];
  wire [5:0] rd_widx = rd_addr[7:2];
  wire bus_wr = wr_stb & wr_ok;

  // Byte-lane merge of a bus write
  function [31:0] merge_strb;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer b;
    begin
      for (b = 0; b < 4; b = b + 1)
        merge_strb[b*8 +: 8] = strb[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
    end
  endfunction

  function is_mapped;
    input [5:0] widx;
    begin
      is_mapped = (widx < (`DCRF_WIDX_GEN + `DCRF_GEN_COUNT));
    end
  endfunction

  // Pin levels come from their own flops
  function [31:0] gen_value;
    input [3:0] sel;
    begin
      case (sel)
        `DCRF_SEL_DP: gen_value = dp_r;
        `DCRF_SEL_IR0: gen_value = ir0_r;
        `DCRF_SEL_IR1: gen_value = ir1_r;
        `DCRF_SEL_BK: gen_value = bk_r;
        `DCRF_SEL_SP: gen_value = sp_r;
        `DCRF_SEL_ST: gen_value = st_r;
        `DCRF_SEL_IE: gen_value = ie_r;
        `DCRF_SEL_IF: gen_value = if_r;
        `DCRF_SEL_IOF: begin
          gen_value = iof_r;
          gen_value[`DCRF_IOF_IN0] = pin0_in_r;
          gen_value[`DCRF_IOF_IN1] = pin1_in_r;
        end
        `DCRF_SEL_RC: gen_value = rc_r;
        `DCRF_SEL_RS: gen_value = rs_r;
        `DCRF_SEL_RE: gen_value = re_r;
        `DCRF_SEL_PC: gen_value = pc_r;
        default: gen_value = `DCRF_RST_WORD;
      endcase
    end
  endfunction

  dcrf_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .awaddr(s_axi_awaddr),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .bresp(s_axi_bresp),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .araddr(s_axi_araddr),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_stb(rd_stb),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // Ext registers: low word, then high byte
  always @* begin
    rd_ok = is_mapped(rd_widx) & (rd_addr[1:0] == 2'h0);
    wr_ok = is_mapped(wr_widx) & (wr_addr[1:0] == 2'h0);
    rd_data = `DCRF_RST_WORD;
    if (rd_widx < `DCRF_WIDX_AUX)
      rd_data = rd_widx[0] ? {24'h000000, ext_r[rd_widx[3:1]][39:32]}
                           : ext_r[rd_widx[3:1]][31:0];
    else if (rd_widx < `DCRF_WIDX_GEN)
      rd_data = aux_r[rd_widx[2:0]];
    else
      rd_data = gen_value(rd_widx[3:0] - 4'h8);
  end

  // CPU port wins over the bus
  always @* begin
    g_wen = 1'b0;
    g_sel = `DCRF_SEL_DP;
    g_data = `DCRF_RST_WORD;
    if (reg_wr_en) begin
      g_wen = 1'b1;
      g_sel = reg_wr_sel;
      g_data = reg_wr_data;
    end else if (bus_wr && wr_widx >= `DCRF_WIDX_GEN) begin
      g_wen = 1'b1;
      g_sel = wr_widx[3:0] - 4'h8;
      g_data = merge_strb(gen_value(wr_widx[3:0] - 4'h8), wr_data, wr_strb);
    end
  end

  // Flag update from a result, or a verbatim load
  always @* begin
    st_nxt = st_r;
    if (g_wen && g_sel == `DCRF_SEL_ST)
      st_nxt = g_data; // RL12
    else if (flag_upd_en) begin
      st_nxt[`DCRF_ST_C] = flag_carry; // RL11
      st_nxt[`DCRF_ST_V] = flag_ovf;
      st_nxt[`DCRF_ST_Z] = flag_float ? (flag_res == 40'h0000000000)
                                      : (flag_res[31:0] == 32'h00000000);
      st_nxt[`DCRF_ST_N] = flag_res[31];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 8; i = i + 1) begin
        ext_r[i] <= `DCRF_RST_EXT;
        aux_r[i] <= `DCRF_RST_WORD;
      end
      ext_rd_r <= `DCRF_RST_EXT;
      aux_rd_r <= `DCRF_RST_WORD;
      dp_r <= `DCRF_RST_WORD;
      ir0_r <= `DCRF_RST_WORD;
      ir1_r <= `DCRF_RST_WORD;
      bk_r <= `DCRF_RST_WORD;
      sp_r <= `DCRF_RST_WORD;
      st_r <= `DCRF_RST_WORD;
      ie_r <= `DCRF_RST_WORD;
      if_r <= `DCRF_RST_WORD;
      iof_r <= `DCRF_RST_WORD;
      rc_r <= `DCRF_RST_WORD;
      rs_r <= `DCRF_RST_WORD;
      re_r <= `DCRF_RST_WORD;
      pc_r <= `DCRF_RST_WORD;
      act_r <= `DCRF_RST_WORD;
      stk_addr_r <= `DCRF_RST_WORD;
      stk_wr_r <= 1'b0;
      stk_rd_r <= 1'b0;
      pin0_in_r <= 1'b0;
      pin1_in_r <= 1'b0;
    end else if (clk_en) begin
      // Datapath wins over bus
      if (bus_wr && wr_widx < `DCRF_WIDX_AUX) begin
        if (wr_widx[0]) begin
          if (wr_strb[0])
            ext_r[wr_widx[3:1]][39:32] <= wr_data[7:0];
        end else
          ext_r[wr_widx[3:1]][31:0] <= merge_strb(ext_r[wr_widx[3:1]][31:0], wr_data, wr_strb);
      end
      if (ext_wr_en) begin
        if (ext_wr_float)
          ext_r[ext_wr_sel] <= ext_wr_data; // RL1
        else
          ext_r[ext_wr_sel][31:0] <= ext_wr_data[31:0]; // RL2
      end
      ext_rd_r <= ext_r[ext_rd_sel]; // RL1

      // Later sources win
      if (bus_wr && wr_widx >= `DCRF_WIDX_AUX && wr_widx < `DCRF_WIDX_GEN)
        aux_r[wr_widx[2:0]] <= merge_strb(aux_r[wr_widx[2:0]], wr_data, wr_strb);
      if (aux_wr_en)
        aux_r[aux_wr_sel] <= aux_wr_data; // RL4
      if (au0_wr_en)
        aux_r[au0_wr_sel] <= au0_wr_data; // RL3
      if (au1_wr_en)
        aux_r[au1_wr_sel] <= au1_wr_data; // RL3
      aux_rd_r <= aux_r[aux_rd_sel]; // RL3

      if (g_wen && g_sel == `DCRF_SEL_DP)
        dp_r <= g_data;
      if (g_wen && g_sel == `DCRF_SEL_IR0)
        ir0_r <= g_data;
      if (g_wen && g_sel == `DCRF_SEL_IR1)
        ir1_r <= g_data;
      if (g_wen && g_sel == `DCRF_SEL_BK)
        bk_r <= g_data;

      // Push with pop cancels; a write wins
      stk_wr_r <= 1'b0;
      stk_rd_r <= 1'b0;
      if (g_wen && g_sel == `DCRF_SEL_SP)
        sp_r <= g_data;
      else if (stk_push && !stk_pop) begin
        sp_r <= sp_r + 32'h00000001; // RL9
        stk_addr_r <= sp_r + 32'h00000001; // RL8
        stk_wr_r <= 1'b1; // RL10
      end else if (stk_pop && !stk_push) begin
        sp_r <= sp_r - 32'h00000001; // RL9
        stk_addr_r <= sp_r; // RL8
        stk_rd_r <= 1'b1; // RL10
      end

      st_r <= st_nxt;
      if (g_wen && g_sel == `DCRF_SEL_IE)
        ie_r <= g_data & `DCRF_IE_MASK; // RL20
      // Requests win over a clearing write
      if (g_wen && g_sel == `DCRF_SEL_IF)
        if_r <= g_data | intr_set; // RL15
      else
        if_r <= if_r | intr_set; // RL15
      act_r <= if_r & ie_r; // RL14

      if (g_wen && g_sel == `DCRF_SEL_IOF)
        iof_r <= g_data & `DCRF_IOF_WMASK; // RL16
      pin0_in_r <= general_pin_0_in; // RL16
      pin1_in_r <= general_pin_1_in;

      if (g_wen && g_sel == `DCRF_SEL_RC)
        rc_r <= g_data; // RL17
      if (g_wen && g_sel == `DCRF_SEL_RS)
        rs_r <= g_data; // RL18
      if (g_wen && g_sel == `DCRF_SEL_RE)
        re_r <= g_data; // RL18

      if (g_wen && g_sel == `DCRF_SEL_PC)
        pc_r <= g_data; // RL19
      else if (pc_load)
        pc_r <= pc_load_data; // RL19
      else if (pc_step)
        pc_r <= pc_r + 32'h00000001;
    end
  end

  assign ext_rd_data = ext_rd_r;
  assign aux_rd_data = aux_rd_r;
  assign page_num = dp_r[7:0]; // RL5
  assign index_0 = ir0_r; // RL6
  assign index_1 = ir1_r; // RL6
  assign block_size = bk_r; // RL7
  assign stack_top = sp_r; // RL8
  assign stk_addr = stk_addr_r;
  assign stk_wr = stk_wr_r;
  assign stk_rd = stk_rd_r;
  assign cpu_flag_word = st_r;
  assign interrupt_enable = ie_r; // RL13
  assign interrupt_flags = if_r;
  assign intr_active = act_r;
  assign general_pin_0_out = iof_r[`DCRF_IOF_OUT0]; // RL16
  assign general_pin_0_oe = iof_r[`DCRF_IOF_DIR0]; // RL16
  assign general_pin_1_out = iof_r[`DCRF_IOF_OUT1];
  assign general_pin_1_oe = iof_r[`DCRF_IOF_DIR1];
  assign loop_count = rc_r;
  assign loop_start_address = rs_r;
  assign loop_end_address = re_r;
  assign program_counter = pc_r;
endmodule // dcrf_regfile

// ### dcrf_cpu_model.sv
// Pad model of the two general pins.
// Assumes no pulls on the pins.
module dcrf_cpu_model (
  input wire logic aclk, // Clock
  input wire logic p0_out, // Pin 0 drive level
  input wire logic p0_oe, // Pin 0 driven when high
  input wire logic p1_out, // Pin 1 drive level
  input wire logic p1_oe, // Pin 1 driven when high
  output logic p0_in, // Pin 0 level
  output logic p1_in // Pin 1 level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last0_r = 1'b0;
  logic last1_r = 1'b0;
  always @(posedge aclk) begin
    if (p0_oe) last0_r <= p0_out;
    if (p1_oe) last1_r <= p1_out;
  end
  // Floating pin shows the inverse, so stale levels are caught
  assign p0_in = p0_oe ? p0_out : ~last0_r;
  assign p1_in = p1_oe ? p1_out : ~last1_r;
endmodule // dcrf_cpu_model

// ### dcrf_regfile_sva.sv
// Checker on the datapath ports of the register file.
// Assumes no bus write lands on a watched register in the same cycle.
`include "dcrf_defines.vh"
module dcrf_regfile_sva (
  input wire logic aclk, aresetn, clk_en, reg_wr_en, stk_push, stk_pop, stk_wr, stk_rd,
  input wire logic flag_upd_en, flag_float, flag_carry, flag_ovf, pc_load, ext_wr_en,
  input wire logic ext_wr_float,
  input wire logic [2:0] ext_wr_sel, ext_rd_sel,
  input wire logic [3:0] reg_wr_sel,
  input wire logic [7:0] page_num,
  input wire logic [39:0] flag_res, ext_wr_data, ext_rd_data,
  input wire logic [31:0] reg_wr_data, stack_top, stk_addr, interrupt_enable, interrupt_flags,
  input wire logic [31:0] intr_active, cpu_flag_word, pc_load_data, program_counter
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire ld_sp = reg_wr_en && reg_wr_sel == `DCRF_SEL_SP;
  wire ld_st = reg_wr_en && reg_wr_sel == `DCRF_SEL_ST;
  wire push_ok = clk_en && stk_push && !stk_pop && !ld_sp;
  wire pop_ok = clk_en && stk_pop && !stk_push && !ld_sp;
  sequence s_ext_wr(bit fl);
    clk_en && ext_wr_en && ext_wr_float == fl && ext_rd_sel == ext_wr_sel
      ##1 clk_en && !ext_wr_en && $stable(ext_rd_sel);
  endsequence
  AST_PAGE: assert property (clk_en && reg_wr_en && reg_wr_sel == `DCRF_SEL_DP
    |=> page_num == $past(reg_wr_data[7:0])) else $error("page number wrong");
  AST_PUSH: assert property (push_ok |=> stack_top == $past(stack_top) + 32'h1
    && stk_wr && stk_addr == stack_top) else $error("push wrong");
  AST_POP: assert property (pop_ok |=> stack_top == $past(stack_top) - 32'h1
    && stk_rd && stk_addr == $past(stack_top)) else $error("pop wrong");
  AST_ST_LOAD: assert property (clk_en && ld_st |=> cpu_flag_word == $past(reg_wr_data))
    else $error("status load wrong");
  AST_FLAGS: assert property (clk_en && flag_upd_en && !ld_st |=> cpu_flag_word[3:0] ==
    {$past(flag_res[31]), $past(flag_float ? flag_res == 40'h0 : flag_res[31:0] == 32'h0),
    $past(flag_ovf), $past(flag_carry)}) else $error("condition flags wrong");
  AST_IE_RSVD: assert property ((interrupt_enable & ~`DCRF_IE_MASK) == 32'h0)
    else $error("reserved enable bit set");
  AST_ACTIVE: assert property (clk_en |=> intr_active ==
    $past(interrupt_flags & interrupt_enable)) else $error("active interrupts wrong");
  AST_PC: assert property (clk_en && pc_load && !(reg_wr_en && reg_wr_sel == `DCRF_SEL_PC)
    |=> program_counter == $past(pc_load_data)) else $error("counter load wrong");
  AST_EXT_FLT: assert property (s_ext_wr(1'b1) |=> ext_rd_data == $past(ext_wr_data, 2))
    else $error("float write wrong");
  AST_EXT_INT: assert property (s_ext_wr(1'b0) |=> ext_rd_data[31:0] ==
    $past(ext_wr_data[31:0], 2) && ext_rd_data[39:32] == $past(ext_rd_data[39:32]))
    else $error("integer write wrong");
endmodule // dcrf_regfile_sva
bind dcrf_regfile dcrf_regfile_sva u_sva (.*);

// ### testbench.sv
// Self-checking bench of the register file.
// Assumes the checker and pin model compile with it.
`include "dcrf_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] OK = `DCRF_RESP_OKAY;
  localparam logic [1:0] SE = `DCRF_RESP_SLVERR;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, page_num;
  logic [3:0] s_axi_wstrb, reg_wr_sel;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic ext_wr_en, ext_wr_float, aux_wr_en, au0_wr_en, au1_wr_en, reg_wr_en, stk_push, stk_pop;
  logic flag_upd_en, flag_float, flag_carry, flag_ovf, pc_load, pc_step, stk_wr, stk_rd;
  logic general_pin_0_in, general_pin_0_out, general_pin_0_oe;
  logic general_pin_1_in, general_pin_1_out, general_pin_1_oe;
  logic [2:0] ext_wr_sel, ext_rd_sel, aux_wr_sel, au0_wr_sel, au1_wr_sel, aux_rd_sel;
  logic [39:0] ext_wr_data, ext_rd_data, flag_res;
  logic [31:0] s_axi_wdata, s_axi_rdata, aux_wr_data, au0_wr_data, au1_wr_data, aux_rd_data;
  logic [31:0] reg_wr_data, index_0, index_1, block_size, stack_top, stk_addr, cpu_flag_word;
  logic [31:0] intr_set, interrupt_enable, interrupt_flags, intr_active, loop_count;
  logic [31:0] loop_start_address, loop_end_address, pc_load_data, program_counter, v, w;
  logic [7:0] ad[6] = '{8'h64, 8'h68, 8'h6C, 8'h84, 8'h88, 8'h8C};
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int err_count = 0, samples_checked = 0;
  dcrf_regfile #(.ADDR_W(8)) u_dut (.*);
  dcrf_cpu_model u_cpu (.aclk(aclk), .p0_out(general_pin_0_out), .p0_oe(general_pin_0_oe),
    .p1_out(general_pin_1_out), .p1_oe(general_pin_1_oe), .p0_in(general_pin_0_in),
    .p1_in(general_pin_1_in));
  always #25 aclk = ~aclk;
  task automatic cmp(string nm, logic [33:0] e, logic [33:0] g);
    samples_checked++;
    if (e !== g) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) cmp("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) cmp("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
  end
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tmo(int n);
    if (n >= 40) begin
      err_count++;
      $display("BAD handshake expected done seen timeout");
      give_verdict();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
    int n = 0;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 40);
    s_axi_bready <= 1'b0;
    tmo(n);
    @(posedge aclk);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] d, logic [1:0] r);
    int n = 0;
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 40);
    s_axi_rready <= 1'b0;
    tmo(n);
    @(posedge aclk);
  endtask
  task automatic ctl(logic [3:0] s, logic [31:0] d);
    reg_wr_en <= 1'b1;
    reg_wr_sel <= s;
    reg_wr_data <= d;
    @(posedge aclk);
    reg_wr_en <= 1'b0;
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr,
      s_axi_araddr, s_axi_wdata, s_axi_wstrb, ext_wr_en, ext_wr_float, ext_wr_sel, ext_rd_sel,
      ext_wr_data, aux_wr_en, au0_wr_en, au1_wr_en, aux_wr_sel, au0_wr_sel, au1_wr_sel,
      aux_rd_sel, aux_wr_data, au0_wr_data, au1_wr_data, reg_wr_en, reg_wr_sel, reg_wr_data,
      stk_push, stk_pop, flag_upd_en, flag_float, flag_res, flag_carry, flag_ovf, intr_set,
      pc_load, pc_load_data, pc_step} = '0;
    void'($urandom(32'he0c5));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h60, 32'h0, OK);
    rd(8'h94, 32'h0, SE);
    wr(8'h94, 32'hFFFFFFFF, SE);
    v = $urandom;
    ctl(`DCRF_SEL_DP, v);
    rd(8'h60, v, OK);
    w = $urandom;
    v = $urandom;
    ext_wr_en <= 1'b1;
    ext_wr_float <= 1'b1;
    ext_wr_sel <= 3'h3;
    ext_rd_sel <= 3'h3;
    ext_wr_data <= {w[7:0], v};
    @(posedge aclk);
    ext_wr_en <= 1'b0;
    repeat (2) @(posedge aclk);
    ext_wr_en <= 1'b1;
    ext_wr_float <= 1'b0;
    ext_wr_data <= {~w[7:0], ~v};
    @(posedge aclk);
    ext_wr_en <= 1'b0;
    @(posedge aclk);
    rd(8'h18, ~v, OK);
    rd(8'h1C, {24'h0, w[7:0]}, OK);
    v = $urandom;
    ctl(`DCRF_SEL_SP, v);
    stk_push <= 1'b1;
    @(posedge aclk);
    clk_en <= 1'b0;
    @(posedge aclk);
    clk_en <= 1'b1;
    @(posedge aclk);
    stk_push <= 1'b0;
    stk_pop <= 1'b1;
    @(posedge aclk);
    stk_pop <= 1'b0;
    rd(8'h70, v + 32'h1, OK);
    v = $urandom;
    ctl(`DCRF_SEL_ST, v);
    flag_upd_en <= 1'b1;
    flag_res <= 40'hFF00000000;
    flag_carry <= 1'b1;
    @(posedge aclk);
    flag_upd_en <= 1'b0;
    rd(8'h74, {v[31:4], 4'h5}, OK);
    v = $urandom;
    wr(8'h78, v, OK);
    rd(8'h78, v & `DCRF_IE_MASK, OK);
    intr_set <= 32'h00010001;
    @(posedge aclk);
    intr_set <= 32'h0;
    rd(8'h7C, 32'h00010001, OK);
    foreach (ad[i]) begin
      v = $urandom;
      wr(ad[i], v, OK);
      rd(ad[i], v, OK);
    end
    v = $urandom;
    w = $urandom;
    {aux_wr_en, au0_wr_en, au1_wr_en} <= 3'h7;
    {aux_wr_sel, au0_wr_sel, au1_wr_sel} <= {3'h5, 3'h2, 3'h5};
    {aux_wr_data, au0_wr_data, au1_wr_data} <= {~v, w, v};
    @(posedge aclk);
    {aux_wr_en, au0_wr_en, au1_wr_en} <= 3'h0;
    rd(8'h54, v, OK);
    rd(8'h48, w, OK);
    pc_load <= 1'b1;
    pc_load_data <= v;
    @(posedge aclk);
    {pc_load, pc_step} <= 2'b01;
    @(posedge aclk);
    pc_step <= 1'b0;
    rd(8'h90, v + 32'h1, OK);
    wr(8'h80, 32'h06, OK);
    rd(8'h80, 32'h8E, OK);
    wr(8'h80, 32'h66, OK);
    rd(8'h80, 32'hEE, OK);
    wr(8'h80, 32'h00, OK);
    rd(8'h80, 32'h00, OK);
    give_verdict();
  end
endmodule // testbench
